//--- hw/serial_link_mon_pkg.sv
package serial_link_mon_pkg;
	localparam int LANES = 8;
	localparam int NTYPES = 3;
	localparam int NPARAM = 14;
	localparam int NSUM = 13;
	// register byte addresses
	localparam logic [11:0] A_CHK_MODE = 12'h300;
	localparam logic [11:0] A_PULSE = 12'h312;
	localparam logic [11:0] A_CGS = 12'h470;
	localparam logic [11:0] A_FRAME = 12'h471;
	localparam logic [11:0] A_CHKOK = 12'h472;
	localparam logic [11:0] A_ILAS = 12'h473;
	localparam logic [11:0] A_LIMIT = 12'h47C;
	localparam logic [11:0] A_RSMASK = 12'h47D;
	localparam logic [11:0] A_LANE_CTRL = 12'h480;
	localparam logic [11:0] A_LANE_HOLD = 12'h488;
	localparam logic [11:0] A_LANE_REACH = 12'h490;
	localparam logic [11:0] A_IEN_MAIN = 12'h4B8;
	localparam logic [11:0] A_IEN_EXTRA = 12'h4B9;
	localparam logic [11:0] A_IST_MAIN = 12'h4BA;
	localparam logic [11:0] A_IST_EXTRA = 12'h4BB;
	// field positions
	localparam int CHK_MODE_BIT = 6;
	localparam int PULSE_SEL_LSB = 4;
	localparam int LANE_EN_LSB = 3;
	localparam int LANE_ACTIVE_BIT = 3;
	localparam int IRQ_ERR_LSB = 5;
	localparam int T_BDE = 0;
	localparam int T_NIT = 1;
	localparam int T_UEK = 2;
	// reset values and counter maximum
	localparam logic [7:0] LIMIT_RST = 8'hFF;
	localparam logic [2:0] RSMASK_RST = 3'h7;
	localparam logic [5:0] LANE_CTRL_RST = 6'h3F;
	localparam logic [7:0] IEN_MAIN_RST = 8'h00;
	localparam logic IEN_EXTRA_RST = 1'b1;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	// link timing in frames and octets, and the disparity error count that forces reinit
	localparam logic [2:0] BDE_REINIT_COUNT = 3'h4;
	localparam int RESYNC_FRAMES = 5;
	localparam int RESYNC_OCTETS = 9;
	localparam int OCTETS_PER_PCLK = 4;
	localparam logic [3:0] SEL_F1 = 4'h0;
	localparam logic [3:0] SEL_F2 = 4'h1;
	localparam logic [3:0] SEL_F4 = 4'h2;
	// received parameter byte indices
	localparam int B_DID = 0;
	localparam int B_BID = 1;
	localparam int B_SCR_L = 3;
	localparam int B_F = 4;
	localparam int B_K = 5;
	localparam int B_M = 6;
	localparam int B_N = 7;
	localparam int B_NP = 8;
	localparam int B_S = 9;
	localparam int B_HD = 10;

	typedef enum logic {LS_RUN = 1'b0, LS_RESYNC = 1'b1} link_state_t;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic [LANES-1:0] unexpected_control_char_error;
		logic [LANES-1:0] not_in_table_error;
		logic [LANES-1:0] bde;
	} lane_err_t;
	typedef struct packed {
		logic [LANES-1:0] cgs;
		logic [LANES-1:0] frame;
		logic [LANES-1:0] ilas;
		logic [4:0] fail;
	} lane_stat_t;
	typedef struct packed {
		logic [NPARAM-1:0][7:0] rx;
		logic [NPARAM-1:0][7:0] cfg;
		logic [LANES-1:0][7:0] rx_sum;
		logic [LANES-1:0][4:0] lid;
	} ilas_t;
endpackage

//--- hw/serial_link_error_irq_monitor.sv
`timescale 1ns/100ps
// How it works
// - irq enables for error over-threshold, bits 7:5
// - bring-up and mismatch enables set by one
// - status bit sits where its enable sits
// - any char error pulses sync request low
// - pulse width select field, bits 7:4
// - enabled over-threshold sets status bits 7:5
// - four disparity errors reinitialize the link
// - reinit sync request: five frames nine octets
// - per-lane monitor enables, reset to on
// - masked counter at threshold requests resync
// - resync mask: uek bit2, nit bit1, bde bit0
// - reinit clears counters, keeps irq status
// - comma lock flag per lane
// - frame alignment flag per lane
// - checksum ok when received equals computed
// - mode 0 sums the parameter fields
// - mode 1 sums parameter bytes plus lane id
// - lane alignment flag per lane
// - bring-up failures set status, write one clears
// - mismatch enable on after reset, w1c status
// - mismatch when local and received params differ
// - hold bit stops counter at max, else wraps
// - one shared threshold, reset to max
// - writing zero to reset bit clears counter
module serial_link_error_irq_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire serial_link_mon_pkg::reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	input wire serial_link_mon_pkg::lane_err_t lane_err_i,
	input wire serial_link_mon_pkg::lane_stat_t lane_stat_i,
	input wire serial_link_mon_pkg::ilas_t ilas_i,
	output logic sync_request_out_n_o,
	output logic link_reinit_o
);
	import serial_link_mon_pkg::*;

	typedef struct packed {
		logic chk_mode;
		logic [7:0] pulse_cfg;
		logic [7:0] limit;
		logic [2:0] rs_mask;
		logic [7:0] ien_main;
		logic ien_extra;
		logic [7:0] ist_main;
		logic ist_extra;
		logic [LANES-1:0][5:0] lane_ctrl;
		logic [LANES-1:0][2:0] hold;
		logic [LANES-1:0][2:0] reached;
		logic [LANES-1:0][NTYPES-1:0][7:0] cnt;
		logic [LANES-1:0] chk_ok;
		logic [2:0] bde_run;
		logic [1:0] pulse_cnt;
		logic [3:0] resync_cnt;
		link_state_t state;
		logic reinit;
		logic sync_n;
		logic [7:0] rdata;
	} mon_state_t;

	mon_state_t st_ff;
	mon_state_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// octets per frame for the selected pulse setting
	function automatic int frame_octets(input logic [3:0] sel);
		case (sel)
			SEL_F2: frame_octets = 2;
			SEL_F4: frame_octets = 4;
			default: frame_octets = 1;
		endcase
	endfunction

	// least whole cycles covering five frames plus nine octets
	function automatic logic [3:0] resync_cycles(input logic [3:0] sel);
		int oct;
		oct = RESYNC_FRAMES * frame_octets(sel) + RESYNC_OCTETS;
		resync_cycles = 4'((oct + OCTETS_PER_PCLK - 1) / OCTETS_PER_PCLK);
	endfunction

	// half a cycle cannot be made on one edge; it rounds up to one
	function automatic logic [1:0] pulse_cycles(input logic [3:0] sel);
		pulse_cycles = (sel == SEL_F4) ? 2'h2 : 2'h1;
	endfunction

	function automatic logic [7:0] lane_checksum(input ilas_t p, input int ln, input logic mode);
		logic [7:0] s;
		s = 8'h00;
		if (mode) begin
			for (int b = 0; b < NSUM; b++) begin
				s = s + p.rx[b];
			end
			s = s + 8'(p.lid[ln]);
		end else begin
			s = p.rx[B_DID] + 8'(p.rx[B_BID][3:0]) + 8'(p.lid[ln]);
			s = s + 8'(p.rx[B_SCR_L][7]) + 8'(p.rx[B_SCR_L][4:0]);
			s = s + p.rx[B_F] + 8'(p.rx[B_K][4:0]) + p.rx[B_M];
			s = s + 8'(p.rx[B_N][4:0]) + 8'(p.rx[B_NP][7:5]) + 8'(p.rx[B_NP][4:0]);
			s = s + 8'(p.rx[B_S][7:5]) + 8'(p.rx[B_S][4:0]) + 8'(p.rx[B_HD][7]);
		end
		lane_checksum = s;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	logic [NTYPES-1:0][LANES-1:0] err_hit;
	logic [NTYPES-1:0] reach_evt;
	logic [2:0] bde_sum;
	logic [3:0] bde_tot;
	logic wr_lane_ctrl;
	logic wr_lane_hold;
	logic [2:0] lane_sel;
	logic mismatch;
	logic trigger;

	always_comb begin
		nxt_st = st_ff;
		err_hit = {lane_err_i.unexpected_control_char_error, lane_err_i.not_in_table_error, lane_err_i.bde};
		reach_evt = '0;
		bde_sum = '0;
		lane_sel = reg_req_i.addr[2:0];
		wr_lane_ctrl = reg_req_i.wr && (reg_req_i.addr[11:3] == A_LANE_CTRL[11:3]);
		wr_lane_hold = reg_req_i.wr && (reg_req_i.addr[11:3] == A_LANE_HOLD[11:3]);
		mismatch = (ilas_i.cfg != ilas_i.rx);
		nxt_st.reinit = 1'b0;

		// software writes
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				A_CHK_MODE: nxt_st.chk_mode = reg_req_i.wdata[CHK_MODE_BIT];
				A_PULSE: nxt_st.pulse_cfg = reg_req_i.wdata;
				A_LIMIT: nxt_st.limit = reg_req_i.wdata;
				A_RSMASK: nxt_st.rs_mask = reg_req_i.wdata[2:0];
				A_IEN_MAIN: nxt_st.ien_main = reg_req_i.wdata;
				A_IEN_EXTRA: nxt_st.ien_extra = reg_req_i.wdata[0];
				A_IST_MAIN: nxt_st.ist_main = st_ff.ist_main & ~reg_req_i.wdata;
				A_IST_EXTRA: nxt_st.ist_extra = st_ff.ist_extra & ~reg_req_i.wdata[0];
				default: ;
			endcase
		end
		if (wr_lane_ctrl) begin
			nxt_st.lane_ctrl[lane_sel] = reg_req_i.wdata[5:0];
		end
		if (wr_lane_hold) begin
			nxt_st.hold[lane_sel] = reg_req_i.wdata[2:0];
		end

		// error counters
		for (int l = 0; l < LANES; l++) begin
			for (int t = 0; t < NTYPES; t++) begin
				if (err_hit[t][l] && st_ff.lane_ctrl[l][LANE_EN_LSB + t]) begin
					if (st_ff.cnt[l][t] == CNT_MAX) begin
						nxt_st.cnt[l][t] = st_ff.hold[l][t] ? CNT_MAX : '0;
					end else begin
						nxt_st.cnt[l][t] = st_ff.cnt[l][t] + 8'h01;
					end
					if (nxt_st.cnt[l][t] == st_ff.limit) begin
						reach_evt[t] = 1'b1;
						nxt_st.reached[l][t] = 1'b1;
					end
				end
				if (wr_lane_ctrl && lane_sel == 3'(l) && !reg_req_i.wdata[t]) begin
					nxt_st.cnt[l][t] = '0;
					nxt_st.reached[l][t] = 1'b0;
				end
			end
			bde_sum = bde_sum + 3'(lane_err_i.bde[l]);
		end

		// four invalid disparity characters since the last reinit
		bde_tot = 4'(st_ff.bde_run) + 4'(bde_sum);
		nxt_st.bde_run = (bde_tot >= 4'(BDE_REINIT_COUNT)) ? BDE_REINIT_COUNT : bde_tot[2:0];
		trigger = (st_ff.state == LS_RUN) && ((bde_tot >= 4'(BDE_REINIT_COUNT))
			|| |(reach_evt & st_ff.rs_mask));

		// sticky interrupt status; a new event beats a same-cycle clear
		nxt_st.ist_main[7:IRQ_ERR_LSB] = nxt_st.ist_main[7:IRQ_ERR_LSB]
			| (reach_evt & st_ff.ien_main[7:IRQ_ERR_LSB]);
		nxt_st.ist_main[4:0] = nxt_st.ist_main[4:0]
			| (lane_stat_i.fail & st_ff.ien_main[4:0]);
		nxt_st.ist_extra = nxt_st.ist_extra | (mismatch & st_ff.ien_extra);

		// checksum flags
		for (int l = 0; l < LANES; l++) begin
			nxt_st.chk_ok[l] = (ilas_i.rx_sum[l] == lane_checksum(ilas_i, l, st_ff.chk_mode));
		end

		// error pulse on the sync request line
		if (|err_hit) begin
			nxt_st.pulse_cnt = pulse_cycles(st_ff.pulse_cfg[7:PULSE_SEL_LSB]);
		end else if (st_ff.pulse_cnt != '0) begin
			nxt_st.pulse_cnt = st_ff.pulse_cnt - 2'h1;
		end

		// link reinitialization
		case (st_ff.state)
			LS_RUN: begin
				if (trigger) begin
					nxt_st.state = LS_RESYNC;
					nxt_st.resync_cnt = resync_cycles(st_ff.pulse_cfg[7:PULSE_SEL_LSB]);
					nxt_st.reinit = 1'b1;
					nxt_st.cnt = '0;
					nxt_st.reached = '0;
					nxt_st.bde_run = '0;
				end
			end
			LS_RESYNC: begin
				nxt_st.resync_cnt = st_ff.resync_cnt - 4'h1;
				if (st_ff.resync_cnt == 4'h1) begin
					nxt_st.state = LS_RUN;
				end
			end
			default: nxt_st.state = LS_RUN;
		endcase
		nxt_st.sync_n = !((nxt_st.pulse_cnt != '0) || (nxt_st.state == LS_RESYNC));

		// read data stands in the cycle after the strobe
		nxt_st.rdata = '0;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				A_CHK_MODE: nxt_st.rdata[CHK_MODE_BIT] = st_ff.chk_mode;
				A_PULSE: nxt_st.rdata = st_ff.pulse_cfg;
				A_CGS: nxt_st.rdata = lane_stat_i.cgs;
				A_FRAME: nxt_st.rdata = lane_stat_i.frame;
				A_CHKOK: nxt_st.rdata = st_ff.chk_ok;
				A_ILAS: nxt_st.rdata = lane_stat_i.ilas;
				A_LIMIT: nxt_st.rdata = st_ff.limit;
				A_RSMASK: nxt_st.rdata = {5'h00, st_ff.rs_mask};
				A_IEN_MAIN: nxt_st.rdata = st_ff.ien_main;
				A_IEN_EXTRA: nxt_st.rdata = {7'h00, st_ff.ien_extra};
				A_IST_MAIN: nxt_st.rdata = st_ff.ist_main;
				A_IST_EXTRA: nxt_st.rdata = {7'h00, st_ff.ist_extra};
				default: begin
					if (reg_req_i.addr[11:3] == A_LANE_CTRL[11:3]) begin
						nxt_st.rdata = {2'h0, st_ff.lane_ctrl[lane_sel]};
					end else if (reg_req_i.addr[11:3] == A_LANE_HOLD[11:3]) begin
						nxt_st.rdata = {5'h00, st_ff.hold[lane_sel]};
					end else if (reg_req_i.addr[11:3] == A_LANE_REACH[11:3]) begin
						nxt_st.rdata = {4'h0, lane_stat_i.cgs[lane_sel], st_ff.reached[lane_sel]};
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
			st_ff.limit <= LIMIT_RST;
			st_ff.rs_mask <= RSMASK_RST;
			st_ff.ien_main <= IEN_MAIN_RST;
			st_ff.ien_extra <= IEN_EXTRA_RST;
			st_ff.lane_ctrl <= {LANES{LANE_CTRL_RST}};
			st_ff.state <= LS_RUN;
			st_ff.sync_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata_o = st_ff.rdata;
	assign sync_request_out_n_o = st_ff.sync_n;
	assign link_reinit_o = st_ff.reinit;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// not-in-table on lane 0: can run long without forcing a reinit
	sequence s_nit_lane0_evt;
		lane_err_i.not_in_table_error[0] && st_ff.lane_ctrl[0][LANE_EN_LSB + T_NIT];
	endsequence
	sequence s_low_two;
		!sync_request_out_n_o [*2];
	endsequence

	AST_W1C_SET_WINS: assert property (
		lane_stat_i.fail[0] && st_ff.ien_main[0] && reg_req_i.wr
		&& reg_req_i.addr == A_IST_MAIN |=> st_ff.ist_main[0])
		else $error("status set lost against clear");
	AST_PULSE_WIDTH: assert property (
		lane_err_i.not_in_table_error[0] && st_ff.pulse_cfg[7:PULSE_SEL_LSB] == SEL_F4 |=> s_low_two)
		else $error("error pulse too short");
	AST_RESYNC_LEN: assert property (
		link_reinit_o && st_ff.resync_cnt == 4'h8 |-> !sync_request_out_n_o [*8])
		else $error("reinit sync request too short");
	AST_REINIT_CLEARS: assert property (
		link_reinit_o |-> st_ff.cnt == '0
		&& ((($past(st_ff.ist_main) & ~st_ff.ist_main) == 8'h00)
		|| $past(reg_req_i.wr && reg_req_i.addr == A_IST_MAIN)))
		else $error("reinit left counters or dropped status");
	AST_HOLD_MAX: assert property (
		s_nit_lane0_evt ##0 (st_ff.cnt[0][T_NIT] == CNT_MAX && st_ff.hold[0][T_NIT])
		|=> st_ff.cnt[0][T_NIT] == CNT_MAX)
		else $error("held counter moved");
	AST_WRAP: assert property (
		s_nit_lane0_evt ##0 (st_ff.cnt[0][T_NIT] == CNT_MAX && !st_ff.hold[0][T_NIT])
		|=> st_ff.cnt[0][T_NIT] == 8'h00)
		else $error("counter did not wrap");
	AST_FOUR_BDE: assert property (
		st_ff.bde_run == 3'h3 && lane_err_i.bde[0] && st_ff.state == LS_RUN |=> link_reinit_o)
		else $error("four disparity errors without reinit");
	AST_MISMATCH: assert property (
		ilas_i.cfg != ilas_i.rx && st_ff.ien_extra |=> st_ff.ist_extra)
		else $error("mismatch not flagged");
	AST_READ_LIMIT: assert property (
		reg_req_i.rd && reg_req_i.addr == A_LIMIT |=> reg_rdata_o == $past(st_ff.limit))
		else $error("threshold read wrong");
endmodule // serial_link_error_irq_monitor

//--- dv/link_tx_model.sv
`timescale 1ns/100ps
module link_tx_model (
	input wire logic clk_i,
	output serial_link_mon_pkg::lane_err_t lane_err_o,
	output serial_link_mon_pkg::lane_stat_t lane_stat_o,
	output serial_link_mon_pkg::ilas_t ilas_o
);
	import serial_link_mon_pkg::*;

	initial begin
		lane_err_o = '0;
		lane_stat_o = '0;
		ilas_o = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// a flagged character lasts one pclk; callers leave a gap between calls
	task automatic send_err(input lane_err_t e);
		lane_err_o <= e;
		@(posedge clk_i);
		lane_err_o <= '0;
	endtask

	// the same flagged character on n back-to-back pclks
	task automatic send_burst(input lane_err_t e, input int n);
		lane_err_o <= e;
		repeat (n) @(posedge clk_i);
		lane_err_o <= '0;
	endtask

	task automatic send_fail(input logic [4:0] f);
		lane_stat_o.fail <= f;
		@(posedge clk_i);
		lane_stat_o.fail <= '0;
	endtask

	task automatic set_stat(input logic [7:0] cgs, input logic [7:0] frm, input logic [7:0] ila);
		lane_stat_o.cgs <= cgs;
		lane_stat_o.frame <= frm;
		lane_stat_o.ilas <= ila;
	endtask

	// parameters stay static once sent, as after a finished alignment sequence
	task automatic set_ilas(input ilas_t v);
		ilas_o <= v;
	endtask
endmodule // link_tx_model

//--- dv/serial_link_error_irq_monitor_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module serial_link_error_irq_monitor_tb;
	import serial_link_mon_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	reg_req_t reg_req = '0;
	logic [7:0] reg_rdata;
	lane_err_t lane_err;
	lane_stat_t lane_stat;
	ilas_t ilas;
	logic sync_n;
	logic reinit;
	int fail_count = 0;
	int total_checks = 0;

	always #50 clk_i = ~clk_i;

	serial_link_error_irq_monitor i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req),
		.reg_rdata_o(reg_rdata), .lane_err_i(lane_err), .lane_stat_i(lane_stat), .ilas_i(ilas),
		.sync_request_out_n_o(sync_n), .link_reinit_o(reinit));
	link_tx_model i_tx (.clk_i(clk_i), .lane_err_o(lane_err), .lane_stat_o(lane_stat),
		.ilas_o(ilas));

	////////////////////////////////////////////////////////////////////////////////
	// every task starts and ends right after a rising edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		reg_req.addr <= a;
		reg_req.wdata <= d;
		reg_req.wr <= 1'b1;
		@(posedge clk_i);
		reg_req.wr <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] d;
		reg_req.addr <= a;
		reg_req.rd <= 1'b1;
		@(posedge clk_i);
		reg_req.rd <= 1'b0;
		#1 d = reg_rdata;
		`CHK(d, e)
		@(posedge clk_i);
	endtask

	task automatic chk_low(input int n);
		for (int i = 0; i < n; i++) begin
			#1 `CHK(sync_n, 1'b0)
			@(posedge clk_i);
		end
		#1 `CHK(sync_n, 1'b1)
		@(posedge clk_i);
	endtask

	// fixed window: long enough for the one-cycle answer, short of the eight-cycle resync end under SEL_F4
	task automatic wait_reinit(input logic exp);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 6; i++) begin
			#1 if (reinit === 1'b1) seen = 1'b1;
			@(posedge clk_i);
		end
		`CHK(seen, exp)
		if (exp && !seen) wrap_up();
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk_rd(A_LIMIT, 8'hFF);
		chk_rd(A_RSMASK, 8'h07);
		chk_rd(A_LANE_CTRL + 12'h7, 8'h3F);
		chk_rd(A_IEN_MAIN, 8'h00);
		chk_rd(A_IEN_EXTRA, 8'h01);
		chk_rd(12'h7FF, 8'h00);
		wr(A_IEN_MAIN, 8'hE0);
		chk_rd(A_IEN_MAIN, 8'hE0);
	endtask

	task automatic t_pulse();
		for (int s = 0; s < 3; s++) begin
			wr(A_PULSE, {s[3:0], 4'h0});
			i_tx.send_err({8'h00, 8'h01, 8'h00});
			chk_low(s == 2 ? 2 : 1);
		end
	endtask

	task automatic t_reinit();
		int len [3] = '{4, 5, 8};
		for (int s = 0; s < 3; s++) begin
			wr(A_PULSE, {s[3:0], 4'h0});
			for (int k = 0; k < 4; k++) begin
				i_tx.send_err({16'h0000, 8'h08 >> k});
				if (k < 3) @(posedge clk_i);
			end
			#1 `CHK(reinit, 1'b1)
			chk_low(len[s]);
		end
	endtask

	task automatic t_limit();
		wr(A_IEN_MAIN, 8'h00);
		wr(A_LIMIT, 8'h01);
		wr(A_RSMASK, 8'h01);
		wr(A_LANE_CTRL, 8'h37);
		i_tx.send_err({8'h00, 8'h00, 8'h01});
		wait_reinit(1'b0);
		i_tx.send_err({8'h00, 8'h04, 8'h00});
		wait_reinit(1'b0);
		i_tx.send_err({8'h00, 8'h00, 8'h02});
		wait_reinit(1'b1);
		wr(A_IEN_MAIN, 8'h40);
		wr(A_LIMIT, 8'h02);
		wr(A_RSMASK, 8'h02);
		i_tx.send_err({8'h00, 8'h08, 8'h00});
		wr(A_LANE_CTRL + 12'h3, 8'h3D);
		wr(A_LANE_CTRL + 12'h3, 8'h3F);
		i_tx.send_err({8'h00, 8'h08, 8'h00});
		wait_reinit(1'b0);
		i_tx.send_err({8'h00, 8'h08, 8'h00});
		wait_reinit(1'b1);
		chk_rd(A_IST_MAIN, 8'h40);
		wr(A_IST_MAIN, 8'h40);
		chk_rd(A_IST_MAIN, 8'h00);
	endtask

	task automatic t_irq();
		i_tx.send_fail(5'h1F);
		chk_rd(A_IST_MAIN, 8'h00);
		wr(A_IEN_MAIN, 8'h1F);
		i_tx.send_fail(5'h1F);
		chk_rd(A_IST_MAIN, 8'h1F);
		wr(A_IST_MAIN, 8'h05);
		chk_rd(A_IST_MAIN, 8'h1A);
	endtask

	task automatic t_flags();
		i_tx.set_stat(8'hA5, 8'h3C, 8'h81);
		chk_rd(A_CGS, 8'hA5);
		wr(A_CGS, 8'h00);
		chk_rd(A_CGS, 8'hA5);
		chk_rd(A_FRAME, 8'h3C);
		chk_rd(A_ILAS, 8'h81);
	endtask

	// lane 1 matches, other lanes see a nonzero computed sum against zero
	task automatic t_chk();
		ilas_t v;
		v = '0;
		v.rx[B_DID] = 8'h10;
		v.rx[B_BID] = 8'hF2;
		v.rx[B_SCR_L] = 8'h81;
		v.lid[1] = 5'h03;
		v.rx_sum[1] = 8'h17;
		i_tx.set_ilas(v);
		@(posedge clk_i);
		chk_rd(A_CHKOK, 8'h02);
		wr(A_CHK_MODE, 8'h40);
		chk_rd(A_CHKOK, 8'h00);
		v.rx_sum[1] = 8'h86;
		i_tx.set_ilas(v);
		@(posedge clk_i);
		chk_rd(A_CHKOK, 8'h02);
		chk_rd(A_IST_EXTRA, 8'h01);
		v.cfg = v.rx;
		i_tx.set_ilas(v);
		@(posedge clk_i);
		wr(A_IST_EXTRA, 8'h01);
		chk_rd(A_IST_EXTRA, 8'h00);
	endtask

	// lane 0 nit counter held at max, then let wrap onto a threshold of one
	task automatic t_hold();
		wr(A_RSMASK, 8'h00);
		wr(A_LANE_HOLD, 8'h02);
		wr(A_LIMIT, 8'hFF);
		i_tx.send_burst({8'h00, 8'h01, 8'h00}, 256);
		chk_rd(A_LANE_REACH, 8'h0A);
		wr(A_LIMIT, 8'h01);
		wr(A_IST_MAIN, 8'hFF);
		wr(A_IEN_MAIN, 8'h40);
		i_tx.send_burst({8'h00, 8'h01, 8'h00}, 2);
		chk_rd(A_IST_MAIN, 8'h00);
		wr(A_LANE_HOLD, 8'h00);
		i_tx.send_burst({8'h00, 8'h01, 8'h00}, 2);
		chk_rd(A_IST_MAIN, 8'h40);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1 `CHK(sync_n, 1'b1)
		@(posedge clk_i);
		t_reset();
		t_pulse();
		t_reinit();
		t_limit();
		t_irq();
		t_flags();
		t_chk();
		t_hold();
		wrap_up();
	end
endmodule // serial_link_error_irq_monitor_tb
